// *** mxb_ctrl.sv ***
// mxb_ctrl.sv: address/data phase sequencer for a shared 24-bit bus
// assumes bus data returns in step with clk_in and the pattern machine
// shares this clock
`timescale 1ns/1ps
`default_nettype none
`include "mxb_cfg.svh"

module mxb_ctrl import mxb_pkg::*; #(
  parameter int NCS = 8,
  parameter int CW = 8
) (
  input wire logic clk_in, // bus clock
  input wire logic reset_in, // sync reset, high
  input wire logic req_valid_in, // dispatcher request
  input wire logic [`MXB_BUS_W-1:0] req_addr_in, // request address
  input wire logic req_write_in, // 1 write, 0 read
  input wire logic req_burst_in, // 8-beat burst
  input wire logic [`MXB_BUS_W-1:0] wdata_in, // write word for next beat
  input wire logic xaddr_req_in, // pattern asks for extra address phase
  input wire logic [`MXB_BUS_W-1:0] xaddr_in, // extra address
  input wire logic [NCS-1:0][`MXB_BUS_W-1:0] bank_base_settings_in, // bases
  input wire logic [NCS-1:0][`MXB_BUS_W-1:0] bank_option_settings_in, // options
  input wire logic [CW-1:0] refresh_timer_count_in, // shared timer count
  input wire logic [CW-1:0] prescale_field_in, // shared prescale
  input wire logic [`MXB_BUS_W-1:0] shared_addr_data_bus_in, // bus pins in
  output logic [`MXB_BUS_W-1:0] shared_addr_data_bus_out, // bus pins out
  output logic shared_addr_data_bus_oe_n_out, // low while driving
  output logic addr_latch_strobe_out, // address latch strobe
  output logic [`MXB_BEAT_W-1:0] low_burst_address_out, // beat index
  output logic transceiver_direction_out, // high outbound
  output logic [NCS-1:0] chip_select_n_out, // chip selects, low active
  output logic refresh_cmd_out, // refresh command strobe
  output logic sdram_req_out, // sdram machine busy on a request
  output logic req_accept_out, // request taken pulse
  output logic req_error_out, // unmapped address pulse
  output logic wdata_take_out, // write word on the bus
  output logic [`MXB_BUS_W-1:0] rdata_out, // read word
  output logic rdata_valid_out // read word pulse
);
  localparam int IW = $clog2(NCS);

  mxb_state_t state_r, state_nxt;
  logic [`MXB_BUS_W-1:0] addr_r, addr_nxt;
  logic [`MXB_BEAT_W-1:0] beat_r, beat_nxt;
  logic [`MXB_BEAT_W-1:0] left_r, left_nxt;
  logic [3:0] hold_r, hold_nxt;
  logic [IW-1:0] cs_r, cs_nxt;
  logic [IW-1:0] ref_idx_r;
  logic ref_ph_r;
  logic write_r, write_nxt;
  logic sdram_r, sdram_nxt;
  logic xpend_r, xpend_nxt;
  logic refpend_r;

  wire hit;
  wire [IW-1:0] hit_idx;
  wire [1:0] hit_mach;
  wire [3:0] hit_hold;
  wire [NCS-1:0] sdram_banks;
  wire expire;

  // ************************************************
  // bank match and shared refresh timer
  // ************************************************
  mxb_cs_match #(.NCS(NCS)) u_match (
    .addr_in(req_addr_in),
    .base_in(bank_base_settings_in),
    .opt_in(bank_option_settings_in),
    .hit_out(hit),
    .idx_out(hit_idx),
    .mach_out(hit_mach),
    .hold_out(hit_hold),
    .sdram_out(sdram_banks)
  );

  // one timer pair serves every sdram select
  mxb_refresh_sched #(.CW(CW)) u_refresh (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .timer_count_in(refresh_timer_count_in),
    .prescale_in(prescale_field_in),
    .expire_out(expire)
  );

  // ************************************************
  // decode
  // ************************************************
  wire idle = (state_r == MXB_IDLE);
  wire do_ref = idle && refpend_r && (|sdram_banks);
  wire take = idle && !do_ref && req_valid_in;
  wire accept = take && hit;
  // the general machine never bursts
  wire burst_ok = req_burst_in && (hit_mach != `MXB_MACH_GENERAL);
  wire in_data = (state_r == MXB_DATA);
  wire xaddr = in_data && xaddr_req_in && !sdram_r;
  wire ref_last = (state_r == MXB_REFR) && ref_ph_r && (ref_idx_r == IW'(NCS - 1));
  wire ref_fire = (state_r == MXB_REFR) && !ref_ph_r && sdram_banks[ref_idx_r];
  wire drive_nxt = (state_nxt == MXB_ADDR) || ((state_nxt == MXB_DATA) && write_nxt);
  wire [NCS-1:0] cs_one = NCS'(1) << cs_nxt;
  wire [NCS-1:0] ref_one = NCS'(1) << ref_idx_r;

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    beat_nxt = beat_r;
    left_nxt = left_r;
    hold_nxt = hold_r;
    cs_nxt = cs_r;
    write_nxt = write_r;
    sdram_nxt = sdram_r;
    xpend_nxt = xpend_r;
    case (state_r)
      MXB_IDLE: begin
        if (do_ref) begin
          state_nxt = MXB_REFR;
        end else if (accept) begin
          state_nxt = MXB_ADDR;
          addr_nxt = req_addr_in;
          beat_nxt = '0;
          left_nxt = burst_ok ? `MXB_BURST_LAST : '0;
          hold_nxt = hit_hold;
          cs_nxt = hit_idx;
          write_nxt = req_write_in;
          sdram_nxt = (hit_mach == `MXB_MACH_SDRAM);
        end
      end
      MXB_ADDR: begin
        state_nxt = MXB_DATA;
      end
      MXB_DATA: begin
        if (xaddr) begin
          addr_nxt = xaddr_in;
          // a write already drives the bus, a read must turn it
          state_nxt = write_r ? MXB_ADDR : MXB_TURN;
          xpend_nxt = !write_r;
        end else if (left_r == '0) begin
          state_nxt = write_r ? MXB_IDLE : MXB_TURN;
        end else begin
          beat_nxt = beat_r + `MXB_BEAT_W'(1);
          left_nxt = left_r - `MXB_BEAT_W'(1);
        end
      end
      MXB_TURN: begin
        xpend_nxt = 1'b0;
        if (xpend_r) begin
          state_nxt = MXB_ADDR;
        end else if (hold_r != '0) begin
          state_nxt = MXB_HOLD;
        end else begin
          state_nxt = MXB_IDLE;
        end
      end
      MXB_HOLD: begin
        hold_nxt = hold_r - 4'h1;
        if (hold_r == 4'h1) begin
          state_nxt = MXB_IDLE;
        end
      end
      MXB_REFR: begin
        if (ref_last) begin
          state_nxt = MXB_IDLE;
        end
      end
      default: state_nxt = MXB_IDLE;
    endcase
  end

  // ************************************************
  // sequencer registers
  // ************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_r <= MXB_IDLE;
      addr_r <= '0;
      beat_r <= '0;
      left_r <= '0;
      hold_r <= '0;
      cs_r <= '0;
      write_r <= 1'b0;
      sdram_r <= 1'b0;
      xpend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      beat_r <= beat_nxt;
      left_r <= left_nxt;
      hold_r <= hold_nxt;
      cs_r <= cs_nxt;
      write_r <= write_nxt;
      sdram_r <= sdram_nxt;
      xpend_r <= xpend_nxt;
    end
  end

  // ************************************************
  // refresh pending and walk over selects
  // ************************************************
  // a new expiry in the clearing cycle keeps the flag set
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      refpend_r <= 1'b0;
      ref_idx_r <= '0;
      ref_ph_r <= 1'b0;
    end else begin
      refpend_r <= expire | (refpend_r & !do_ref);
      ref_ph_r <= (state_r == MXB_REFR) && !ref_ph_r;
      if (state_r != MXB_REFR || ref_last) begin
        ref_idx_r <= '0;
      end else if (ref_ph_r) begin
        ref_idx_r <= ref_idx_r + IW'(1);
      end
    end
  end

  // ************************************************
  // pin registers
  // ************************************************
  // all pins come from flops, set from the next state, except the refresh command and its select, set from the current refresh phase
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      shared_addr_data_bus_out <= '0;
      shared_addr_data_bus_oe_n_out <= 1'b1;
      addr_latch_strobe_out <= 1'b0;
      low_burst_address_out <= '0;
      transceiver_direction_out <= 1'b1;
      chip_select_n_out <= '1;
      refresh_cmd_out <= 1'b0;
      sdram_req_out <= 1'b0;
    end else begin
      shared_addr_data_bus_out <= (state_nxt == MXB_ADDR) ? addr_nxt : wdata_in;
      shared_addr_data_bus_oe_n_out <= !drive_nxt;
      addr_latch_strobe_out <= (state_nxt == MXB_ADDR);
      low_burst_address_out <= addr_nxt[`MXB_BEAT_W-1:0] + beat_nxt;
      transceiver_direction_out <= !((state_nxt == MXB_DATA) && !write_nxt);
      chip_select_n_out <= (state_nxt == MXB_DATA) ? ~cs_one : '1;
      if (ref_fire) begin
        chip_select_n_out <= ~ref_one;
      end
      refresh_cmd_out <= ref_fire;
      sdram_req_out <= sdram_nxt && (state_nxt != MXB_IDLE) && (state_nxt != MXB_REFR);
    end
  end

  // ************************************************
  // dispatcher side answers
  // ************************************************
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      req_accept_out <= 1'b0;
      req_error_out <= 1'b0;
      wdata_take_out <= 1'b0;
      rdata_out <= '0;
      rdata_valid_out <= 1'b0;
    end else begin
      req_accept_out <= accept;
      req_error_out <= take && !hit;
      wdata_take_out <= (state_nxt == MXB_DATA) && write_nxt;
      rdata_valid_out <= in_data && !write_r;
      if (in_data && !write_r) begin
        rdata_out <= shared_addr_data_bus_in;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  sequence s_turn;
    state_r == MXB_TURN && transceiver_direction_out && shared_addr_data_bus_oe_n_out;
  endsequence
  sequence s_addr;
    addr_latch_strobe_out && !shared_addr_data_bus_oe_n_out;
  endsequence

  addr_phase_a: assert property (addr_latch_strobe_out
    |-> !shared_addr_data_bus_oe_n_out && transceiver_direction_out)
    else $error("address phase without bus drive or outbound direction");
  read_float_a: assert property (in_data && !write_r
    |-> shared_addr_data_bus_oe_n_out && !transceiver_direction_out)
    else $error("read data phase with bus driven");
  read_turn_a: assert property (in_data && !write_r && !xaddr && left_r == '0
    |=> s_turn)
    else $error("no turnaround after read");
  xaddr_turn_a: assert property (xaddr && !write_r |=> s_turn ##1 s_addr)
    else $error("extra address during read lacks one turnaround");
  xaddr_write_a: assert property (xaddr && write_r |=> s_addr)
    else $error("extra address during write delayed");
  beat_step_a: assert property (in_data && !xaddr && left_r != '0
    |=> low_burst_address_out == $past(low_burst_address_out) + 3'h1)
    else $error("beat index did not advance");
  general_single_a: assert property (accept && hit_mach == `MXB_MACH_GENERAL
    |=> left_r == '0)
    else $error("burst on general machine");
  cs_single_a: assert property ($onehot0(~chip_select_n_out))
    else $error("more than one chip select active");
  ref_gap_a: assert property (refresh_cmd_out |=> !refresh_cmd_out)
    else $error("refresh commands not separated");
  ref_first_a: assert property (refpend_r && idle && |sdram_banks
    |=> state_r == MXB_REFR && !req_accept_out)
    else $error("request started ahead of pending refresh");
  hold_len_a: assert property (state_r == MXB_TURN && !xpend_r && hold_r == 4'h2
    |=> state_r == MXB_HOLD [*2] ##1 idle)
    else $error("read hold length wrong");
  sdram_req_a: assert property (accept && hit_mach == `MXB_MACH_SDRAM
    |=> sdram_req_out)
    else $error("sdram bank not sent to sdram machine");
endmodule // mxb_ctrl

`default_nettype wire

// *** mxb_cfg.svh ***
// mxb_cfg.svh: offsets, field positions, codes and counts for the muxed bus controller
// assumes inclusion by bare name from every design file that needs it
`ifndef MXB_CFG_SVH
`define MXB_CFG_SVH

// ************************************************
// bus geometry
// ************************************************
`define MXB_BUS_W 24
`define MXB_BEAT_W 3
`define MXB_BURST_LAST 3'h7

// ************************************************
// bank base settings fields
// ************************************************
`define MXB_BASE_VALID 0
`define MXB_BASE_MACH_LO 1
`define MXB_BASE_MACH_HI 2
`define MXB_MATCH_LO 8

// ************************************************
// machine codes held in the base settings
// ************************************************
`define MXB_MACH_GENERAL 2'h0
`define MXB_MACH_PATTERN 2'h1
`define MXB_MACH_SDRAM 2'h2

// ************************************************
// bank option settings fields
// ************************************************
`define MXB_OPT_HOLD_LO 0
`define MXB_OPT_HOLD_HI 3

// ************************************************
// timing counts in bus clocks
// ************************************************
`define MXB_TURN_CYCLES 1
`define MXB_REF_GAP 1

`endif

// *** mxb_pkg.sv ***
// mxb_pkg.sv: types shared by the muxed bus controller modules
// assumes mxb_cfg.svh carries the numbers
`default_nettype none

package mxb_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    MXB_IDLE,
    MXB_ADDR,
    MXB_DATA,
    MXB_TURN,
    MXB_HOLD,
    MXB_REFR
  } mxb_state_t;
endpackage

`default_nettype wire

// *** mxb_refresh_sched.sv ***
// mxb_refresh_sched.sv: shared refresh timer with prescaler
// assumes timer count and prescale are held stable by software
`timescale 1ns/1ps
`default_nettype none
`include "mxb_cfg.svh"

module mxb_refresh_sched import mxb_pkg::*; #(
  parameter int CW = 8
) (
  input wire logic clk_in, // bus clock
  input wire logic reset_in, // sync reset, high
  input wire logic [CW-1:0] timer_count_in, // refresh timer count
  input wire logic [CW-1:0] prescale_in, // prescale field
  output logic expire_out // expiry pulse, one cycle wide unless count and prescale are both 1
);
  logic [CW-1:0] pre_r;
  logic [CW-1:0] tmr_r;
  logic [2*CW-1:0] gap_r;
  logic seen_r;

  // ************************************************
  // divider and timer
  // ************************************************
  // a zero field stops the timer rather than firing every clock
  wire run = (timer_count_in != '0) && (prescale_in != '0);
  wire tick = run && (pre_r == CW'(1));
  wire fire = tick && (tmr_r == CW'(1));

  // period is count times prescale clocks
  always_ff @(posedge clk_in) begin
    if (reset_in || !run) begin
      pre_r <= '0;
      tmr_r <= '0;
      expire_out <= 1'b0;
    end else begin
      pre_r <= (pre_r <= CW'(1)) ? prescale_in : pre_r - CW'(1);
      if (tmr_r == '0 || fire) begin
        tmr_r <= timer_count_in;
      end else if (tick) begin
        tmr_r <= tmr_r - CW'(1);
      end
      expire_out <= fire;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  // gap counter between expiries, read only by the check
  always_ff @(posedge clk_in) begin
    if (reset_in || !run) begin
      gap_r <= '0;
      seen_r <= 1'b0;
    end else begin
      gap_r <= expire_out ? '0 : gap_r + (2*CW)'(1);
      seen_r <= seen_r | expire_out;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  ref_period_a: assert property (expire_out && seen_r && $stable(timer_count_in)
    |-> gap_r == (2*CW)'(timer_count_in * prescale_in) - (2*CW)'(1))
    else $error("refresh period differs from count times prescale");
  ref_pulse_a: assert property (expire_out && prescale_in > CW'(1)
    |=> !expire_out)
    else $error("refresh expiry longer than one cycle");
endmodule // mxb_refresh_sched

`default_nettype wire

// *** mxb_cs_match.sv ***
// mxb_cs_match.sv: chip-select address compare across all banks
// assumes base and option settings are static while requests run
`timescale 1ns/1ps
`default_nettype none
`include "mxb_cfg.svh"

module mxb_cs_match import mxb_pkg::*; #(
  parameter int NCS = 8
) (
  input wire logic [`MXB_BUS_W-1:0] addr_in, // transaction address
  input wire logic [NCS-1:0][`MXB_BUS_W-1:0] base_in, // bank base settings
  input wire logic [NCS-1:0][`MXB_BUS_W-1:0] opt_in, // bank option settings
  output logic hit_out, // some bank matched
  output logic [$clog2(NCS)-1:0] idx_out, // matched bank
  output logic [1:0] mach_out, // machine of matched bank
  output logic [3:0] hold_out, // extra read hold clocks
  output logic [NCS-1:0] sdram_out // banks on the sdram machine
);
  logic [NCS-1:0] hit_vec;

  // ************************************************
  // per bank compare
  // ************************************************
  // option upper bits act as a compare mask
  genvar g;
  generate
    for (g = 0; g < NCS; g++) begin : g_bank
      wire [`MXB_BUS_W-1:0] diff = (addr_in ^ base_in[g]) & opt_in[g];
      assign hit_vec[g] = base_in[g][`MXB_BASE_VALID]
        && (diff[`MXB_BUS_W-1:`MXB_MATCH_LO] == '0);
      assign sdram_out[g] = base_in[g][`MXB_BASE_VALID]
        && (base_in[g][`MXB_BASE_MACH_HI:`MXB_BASE_MACH_LO] == `MXB_MACH_SDRAM);
    end
  endgenerate

  // ************************************************
  // pick one bank
  // ************************************************
  // lowest index wins so overlapping banks still select one
  always_comb begin
    idx_out = '0;
    for (int i = NCS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        idx_out = ($clog2(NCS))'(i);
      end
    end
  end

  assign hit_out = |hit_vec;
  assign mach_out = base_in[idx_out][`MXB_BASE_MACH_HI:`MXB_BASE_MACH_LO];
  assign hold_out = opt_in[idx_out][`MXB_OPT_HOLD_HI:`MXB_OPT_HOLD_LO];
endmodule // mxb_cs_match

`default_nettype wire

// *** mxb_far_mem.sv ***
// mxb_far_mem.sv: far-side memory seen through the address latch and transceiver
// assumes the bench resolves the shared bus from the controller's output enable
`timescale 1ns/1ps
`default_nettype none

module mxb_far_mem (
  input wire logic clk_in, // bus clock
  input wire logic [23:0] bus_in, // resolved shared bus
  input wire logic strobe_in, // address latch strobe
  input wire logic [2:0] beat_in, // beat index pins
  input wire logic dir_in, // transceiver direction
  input wire logic [7:0] cs_n_in, // chip selects, low active
  output logic [23:0] data_out // value offered to the bus
);
  logic [20:0] upper_r = 21'h0;
  logic [23:0] last_r = 24'h0;
  // drive only in a selected read beat, released right after sampling
  wire logic drive_w = !dir_in && (cs_n_in != 8'hFF);
  // upper bits come from the latch, low bits straight from the beat pins
  always_ff @(posedge clk_in) begin
    if (strobe_in) upper_r <= bus_in[23:3];
    last_r <= data_out;
  end
  // a released bus shows a changing pattern so stale data never looks valid
  assign data_out = drive_w ? ({upper_r, beat_in} ^ 24'hA5A5A5) : ~last_r;
endmodule // mxb_far_mem

`default_nettype wire

// *** tb.sv ***
// tb.sv: self-checking bench for the muxed bus sequencer
// assumes mxb_pkg and mxb_cfg.svh compiled first; model in mxb_far_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "mxb_cfg.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb import mxb_pkg::*;;
  typedef struct {bit w; bit b; logic [23:0] a; int idx; int hold; int nb;} mxb_row_t;
  logic clk_in = 0, reset_in = 1, req_valid_in = 0, req_write_in = 0, req_burst_in = 0;
  logic xaddr_req_in = 0, prev_oe_n = 1;
  logic [23:0] req_addr_in = 0, xaddr_in = 24'h0002A3, wd_exp = 0, cur_addr = 0;
  logic [7:0][23:0] base_r = 0, opt_r = 0;
  logic [7:0] tcount = 0, pscale = 0;
  wire logic [23:0] bus_out, bus_in, mdata, rdata;
  wire logic [7:0] cs_n;
  wire logic [2:0] beat_idx;
  wire logic oe_n, stb, dir, rcmd, sreq, acc, err, wtake, rval;
  int fails = 0, n_checks = 0, cyc = 0, last_rd = -100, last_hold = 0, x_cyc = -100, xs = 0;
  int wbeat, rbeat, vbeat, cur_idx, cur_hold, nref = 0, last_ref = -100, burst_t = -1;
  bit loose = 0, b2b = 0, xrd = 0, xarm = 0, traffic = 0;
  mxb_row_t rows [8];

  always #5 clk_in = ~clk_in;
  assign bus_in = oe_n ? mdata : bus_out;
  mxb_ctrl i_mxb_ctrl (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
    .req_addr_in(req_addr_in), .req_write_in(req_write_in), .req_burst_in(req_burst_in),
    .wdata_in(wd_exp), .xaddr_req_in(xaddr_req_in), .xaddr_in(xaddr_in),
    .bank_base_settings_in(base_r), .bank_option_settings_in(opt_r),
    .refresh_timer_count_in(tcount), .prescale_field_in(pscale), .shared_addr_data_bus_in(bus_in),
    .shared_addr_data_bus_out(bus_out), .shared_addr_data_bus_oe_n_out(oe_n),
    .addr_latch_strobe_out(stb), .low_burst_address_out(beat_idx),
    .transceiver_direction_out(dir),
    .chip_select_n_out(cs_n), .refresh_cmd_out(rcmd), .sdram_req_out(sreq),
    .req_accept_out(acc), .req_error_out(err), .wdata_take_out(wtake), .rdata_out(rdata),
    .rdata_valid_out(rval));
  mxb_far_mem i_mxb_far_mem (.clk_in(clk_in), .bus_in(bus_in), .strobe_in(stb),
    .beat_in(beat_idx),
    .dir_in(dir), .cs_n_in(cs_n), .data_out(mdata));

  function automatic logic [23:0] exp_rd(input logic [23:0] a, input int k);
    return {a[23:3], 3'(a[2:0] + k)} ^ 24'hA5A5A5;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // port monitor, sampled mid-cycle
  // ****************************************
  always @(negedge clk_in) if (!reset_in) begin
    cyc++;
    if (stb) begin
      `CHK("addr_phase", cur_addr, bus_out)
      `CHK("addr_dir", 2'b10, {dir, oe_n})
      `CHK("sdram_req", cur_idx >= 2, sreq)
      if (b2b) `CHK("read_gap", 3 + last_hold, cyc - last_rd)
      if (traffic) `CHK("ref_busy", 1'b1, cyc - burst_t > 11)
      if (cyc - x_cyc <= 3) begin
        `CHK("x_delay", xrd ? 2 : 1, cyc - x_cyc)
        `CHK("x_turn", xrd, prev_oe_n)
        xs++;
      end
    end
    if (!dir) begin
      if (!loose) begin
        `CHK("rd_float", 1'b1, oe_n)
        `CHK("rd_beat", 3'(cur_addr[2:0] + rbeat), beat_idx)
        `CHK("rd_cs", ~(8'h01 << cur_idx), cs_n)
      end
      rbeat++;
      last_rd = cyc;
      last_hold = cur_hold;
    end
    if (wtake) begin
      if (!loose) begin
        `CHK("wr_data", wd_exp, bus_out)
        `CHK("wr_beat", 3'(cur_addr[2:0] + wbeat), beat_idx)
        `CHK("wr_cs", ~(8'h01 << cur_idx), cs_n)
      end
      wbeat++;
      wd_exp = wd_exp + 24'h1;
    end
    if (rval) begin
      if (!loose) `CHK("rd_data", exp_rd(cur_addr, vbeat), rdata)
      vbeat++;
    end
    // one command per sdram select, one idle clock between them
    if (rcmd) begin
      `CHK("ref_cs", ~(8'h01 << (nref % 2 + 2)), cs_n)
      if (cyc - last_ref < 8) `CHK("ref_gap", 2, cyc - last_ref)
      else begin
        if (burst_t >= 0 && !traffic) `CHK("ref_period", 40, cyc - burst_t)
        burst_t = cyc;
      end
      nref++;
      last_ref = cyc;
    end
    // extra address phase requested inside the data phase
    if (xarm && (xrd ? !dir : wtake)) begin
      xaddr_req_in <= 1'b1;
      x_cyc = cyc;
      cur_addr = xaddr_in;
      xarm = 0;
    end else xaddr_req_in <= 1'b0;
    prev_oe_n = oe_n;
  end

  task automatic run(input bit w, b, input logic [23:0] a, input int idx, hold, nb, gap);
    int k;
    @(posedge clk_in);
    cur_addr = a; cur_idx = idx; cur_hold = hold; wbeat = 0; rbeat = 0; vbeat = 0;
    @(negedge clk_in);
    // write data is a design input too, so it changes off the sampling edge
    req_valid_in = 1; req_addr_in = a; req_write_in = w; req_burst_in = b;
    wd_exp = ~a;
    for (k = 0; !(acc || err); k++) begin
      @(negedge clk_in);
      if (k > 80) begin fails++; complete_run(); end
    end
    `CHK("req_err", nb == 0, err)
    `CHK("req_acc", nb != 0, acc)
    req_valid_in = 0;
    for (k = 0; (w ? wbeat : vbeat) < nb; k++) begin
      @(negedge clk_in);
      if (k > 80) begin fails++; complete_run(); end
    end
    repeat (gap) @(negedge clk_in);
    if (!loose) `CHK("beats", nb, w ? wbeat : vbeat)
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    // banks 0..3: general, pattern, sdram, sdram; sdram options kept identical
    for (int k = 0; k < 4; k++) begin
      base_r[k] = {16'(k + 1), 5'h00, (k > 2) ? 2'h2 : 2'(k), 1'b1};
      opt_r[k] = {16'hFFFF, 4'h0, (k == 1) ? 4'h2 : 4'h0};
    end
    rows = '{'{1, 0, 24'h000105, 0, 0, 1}, '{0, 0, 24'h000106, 0, 0, 1},
      '{0, 1, 24'h000107, 0, 0, 1}, '{1, 1, 24'h000203, 1, 0, 8}, '{0, 1, 24'h000206, 1, 2, 8},
      '{1, 1, 24'h000301, 2, 0, 8}, '{0, 1, 24'h000407, 3, 0, 8}, '{0, 0, 24'h000900, 0, 0, 0}};
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("rst_out", {3'b101, 8'hFF, 51'h0}, {oe_n, stb, dir, cs_n, bus_out, beat_idx, rdata})
    reset_in = 0;
    foreach (rows[i]) run(rows[i].w, rows[i].b, rows[i].a, rows[i].idx, rows[i].hold,
      rows[i].nb, 6);
    // read with extended hold, next request already waiting
    run(0, 0, 24'h000206, 1, 2, 1, 0);
    b2b = 1;
    run(1, 0, 24'h000105, 0, 0, 1, 6);
    b2b = 0;
    // extra address phases on the pattern bank, read then write
    loose = 1; xrd = 1; xarm = 1;
    run(0, 1, 24'h000203, 1, 0, 1, 12);
    xrd = 0; xarm = 1;
    run(1, 1, 24'h000203, 1, 0, 1, 12);
    `CHK("x_count", 2, xs)
    loose = 0;
    // refresh alone, then under traffic
    tcount = 8'h0A; pscale = 8'h04;
    repeat (130) @(negedge clk_in);
    `CHK("ref_seen", 1'b1, nref >= 4)
    traffic = 1;
    k_loop: for (int k = 0; k < 12; k++) run(rows[3 + k % 4].w, rows[3 + k % 4].b,
      rows[3 + k % 4].a, rows[3 + k % 4].idx, rows[3 + k % 4].hold, 8, 2);
    `CHK("ref_traffic", 1'b1, nref >= 8)
    complete_run();
  end
endmodule // tb

`default_nettype wire
